// ===== nv_param_store.sv
// Function
// - save key on save subindex starts save
// - finished save overwrites key with one
// - subindex one all, two..six single categories
// - discard key deletes stored category values
// - discard all keeps tuning; six clears tuning
// - discard leaves working values until restart
// - reboot key on reboot subindex one restarts
// - marker writable, saved with save all
// - savable writes clear marker, except marker
// - master saves only at motor standstill
// - master waits for one before trusting; nv_master raises its done interrupt on the ack, and the host polls for one
// - master treats zero marker as modified; nv_master never reads the marker
// - tuning holds pole pairs, currents, feedback
// - drive holds submode, inertia, current, speed
// - only whole categories are ever stored
// - stored values reload at every reset
//
// The register offsets and strobed register access were decided locally.
module nv_param_store #(
    parameter int NV_CYCLES = nv_pkg::NV_CYCLES
) (
    input wire logic clk, // clock
    input wire logic arst_n, // async reset
    nv_link_if.device link, // master link
    input wire logic [31:0] working_in [nv_pkg::NCAT], // live params
    output logic [31:0] working_out [nv_pkg::NCAT], // loaded params
    output logic load_pulse, // reload strobe
    output logic restart_req // restart request
);
    typedef enum logic [1:0] {
        IDLE = 2'b00, STORE = 2'b01, BOOT = 2'b10
    } state_type;
    state_type state_reg;
    logic [$clog2(NV_CYCLES+1)-1:0] cnt_reg;
    // one word per category stands in for its object set
    logic [31:0] nv_mem [nv_pkg::NCAT];
    logic [nv_pkg::NCAT-1:0] nv_valid_reg = '0; // erased at power-up
    logic [31:0] live_prev_reg [nv_pkg::NCAT];
    logic [31:0] work_reg [nv_pkg::NCAT];
    logic [31:0] save_sub_reg [6];
    logic [31:0] disc_sub_reg [6];
    logic [31:0] marker_reg [2];
    logic [31:0] nv_marker [2];
    logic [4:0] op_mask_reg;
    logic op_disc_reg;
    logic [2:0] op_idx_reg;
    logic op_all_reg;
    logic wr;
    logic [2:0] idx;
    logic key_ok;
    logic start;

    assign wr = link.req && link.we;
    assign idx = link.sub[2:0] - 3'h1;
    assign key_ok = (link.sub >= nv_pkg::SUB_ALL)
        && (link.sub <= nv_pkg::SUB_TUNE);
    assign start = wr && key_ok && state_reg == IDLE
        && ((link.obj == nv_pkg::OBJ_SAVE
             && link.wdata == nv_pkg::SAVE_KEY)
         || (link.obj == nv_pkg::OBJ_DISCARD
             && link.wdata == nv_pkg::DISCARD_KEY));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= BOOT;
            cnt_reg <= '0;
            op_mask_reg <= 5'h00;
            op_disc_reg <= 1'b0;
            op_idx_reg <= 3'h0;
            op_all_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                BOOT: state_reg <= IDLE;
                IDLE: begin
                    if (start) begin
                        state_reg <= STORE;
                        cnt_reg <= '0;
                        op_disc_reg <= link.obj == nv_pkg::OBJ_DISCARD;
                        op_mask_reg <= nv_pkg::cat_mask(link.sub,
                            link.obj == nv_pkg::OBJ_DISCARD);
                        op_idx_reg <= idx;
                        op_all_reg <= link.sub == nv_pkg::SUB_ALL;
                    end
                end
                STORE: begin
                    // long storage write modelled by a fixed wait
                    if (cnt_reg == ($clog2(NV_CYCLES+1))'(NV_CYCLES - 1))
                        state_reg <= IDLE;
                    else
                        cnt_reg <= cnt_reg + 1'b1;
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    wire done = state_reg == STORE
        && cnt_reg == ($clog2(NV_CYCLES+1))'(NV_CYCLES - 1);

    // nonvolatile content survives reset: no reset on these
    always_ff @(posedge clk) begin
        if (done) begin
            for (int i = 0; i < nv_pkg::NCAT; i++) begin
                if (op_mask_reg[i] && !op_disc_reg)
                    nv_mem[i] <= work_reg[i];
            end
            if (op_all_reg && !op_disc_reg) begin
                nv_marker[0] <= marker_reg[0];
                nv_marker[1] <= marker_reg[1];
            end
        end
    end

    // part of the stored image: a reset must not forget what was saved
    always_ff @(posedge clk) begin
        if (done)
            for (int i = 0; i < nv_pkg::NCAT; i++)
                if (op_mask_reg[i])
                    nv_valid_reg[i] <= !op_disc_reg;
    end

    // working copies change on reload, host write or live change, never on discard
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < nv_pkg::NCAT; i++)
                work_reg[i] <= 32'h00000000;
        end else if (state_reg == BOOT) begin
            for (int i = 0; i < nv_pkg::NCAT; i++)
                work_reg[i] <= nv_valid_reg[i] ? nv_mem[i]
                                               : 32'h00000000;
        end else if (wr && link.obj == nv_pkg::OBJ_PARAM
                     && link.sub < 8'(nv_pkg::NCAT)) begin
            work_reg[link.sub[2:0]] <= link.wdata;
        end else begin
            // only a change on the live side is taken over, so a steady
            // input cannot undo a reload or a host write
            for (int i = 0; i < nv_pkg::NCAT; i++)
                if (working_in[i] != live_prev_reg[i])
                    work_reg[i] <= working_in[i];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            for (int i = 0; i < nv_pkg::NCAT; i++)
                live_prev_reg[i] <= 32'h00000000;
        else
            for (int i = 0; i < nv_pkg::NCAT; i++)
                live_prev_reg[i] <= working_in[i];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 6; i++) begin
                save_sub_reg[i] <= nv_pkg::DONE_VALUE;
                disc_sub_reg[i] <= nv_pkg::DONE_VALUE;
            end
        end else if (done) begin
            if (op_disc_reg)
                disc_sub_reg[op_idx_reg] <= nv_pkg::DONE_VALUE;
            else
                save_sub_reg[op_idx_reg] <= nv_pkg::DONE_VALUE;
        end else if (start) begin
            if (link.obj == nv_pkg::OBJ_SAVE)
                save_sub_reg[idx] <= link.wdata;
            else
                disc_sub_reg[idx] <= link.wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            marker_reg[0] <= nv_pkg::MARKER_CLEAR;
            marker_reg[1] <= nv_pkg::MARKER_CLEAR;
        end else if (state_reg == BOOT) begin
            marker_reg[0] <= nv_valid_reg[nv_pkg::CAT_COMM]
                ? nv_marker[0] : nv_pkg::MARKER_CLEAR;
            marker_reg[1] <= nv_valid_reg[nv_pkg::CAT_COMM]
                ? nv_marker[1] : nv_pkg::MARKER_CLEAR;
        end else if (wr && link.obj == nv_pkg::OBJ_MARKER
                     && (link.sub == 8'h01 || link.sub == 8'h02)) begin
            marker_reg[link.sub[1]] <= link.wdata;
        end else if (wr && (link.obj == nv_pkg::OBJ_PARAM
                 || link.obj == nv_pkg::OBJ_DISCARD
                 || (link.obj == nv_pkg::OBJ_SAVE
                     && link.sub != nv_pkg::SUB_ALL))) begin
            marker_reg[0] <= nv_pkg::MARKER_CLEAR;
            marker_reg[1] <= nv_pkg::MARKER_CLEAR;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.ack <= 1'b0;
            link.rdata <= 32'h00000000;
            link.busy <= 1'b0;
            load_pulse <= 1'b0;
            restart_req <= 1'b0;
        end else begin
            link.ack <= link.req;
            link.busy <= state_reg == STORE || start;
            load_pulse <= state_reg == BOOT;
            restart_req <= wr && link.obj == nv_pkg::OBJ_REBOOT
                && link.sub == 8'h01
                && link.wdata == nv_pkg::REBOOT_KEY;
            unique case (link.obj)
                nv_pkg::OBJ_SAVE: link.rdata <= key_ok
                    ? save_sub_reg[idx] : 32'h00000000;
                nv_pkg::OBJ_DISCARD: link.rdata <= key_ok
                    ? disc_sub_reg[idx] : 32'h00000000;
                nv_pkg::OBJ_MARKER: link.rdata <= marker_reg[link.sub[1]];
                nv_pkg::OBJ_PARAM: link.rdata <= link.sub < 8'(nv_pkg::NCAT)
                    ? work_reg[link.sub[2:0]] : 32'h00000000;
                default: link.rdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            for (int i = 0; i < nv_pkg::NCAT; i++)
                working_out[i] <= 32'h00000000;
        else
            for (int i = 0; i < nv_pkg::NCAT; i++)
                working_out[i] <= work_reg[i];
    end
endmodule // nv_param_store

// ===== nv_pkg.sv
package nv_pkg;
    localparam logic [31:0] SAVE_KEY = 32'h65766173;
    localparam logic [31:0] DISCARD_KEY = 32'h64616F6C;
    localparam logic [31:0] REBOOT_KEY = 32'h746F6F62;
    localparam logic [31:0] DONE_VALUE = 32'h00000001;
    localparam logic [31:0] MARKER_CLEAR = 32'h00000000;
    // object selector on the link
    localparam logic [2:0] OBJ_SAVE = 3'h0;
    localparam logic [2:0] OBJ_DISCARD = 3'h1;
    localparam logic [2:0] OBJ_MARKER = 3'h2;
    localparam logic [2:0] OBJ_REBOOT = 3'h3;
    localparam logic [2:0] OBJ_PARAM = 3'h4;
    // subindex to category
    localparam logic [7:0] SUB_ALL = 8'h01;
    localparam logic [7:0] SUB_COMM = 8'h02;
    localparam logic [7:0] SUB_APPL = 8'h03;
    localparam logic [7:0] SUB_CUST = 8'h04;
    localparam logic [7:0] SUB_DRIVE = 8'h05;
    localparam logic [7:0] SUB_TUNE = 8'h06;
    localparam int NCAT = 5;
    // category bit positions in a mask
    localparam int CAT_COMM = 0;
    localparam int CAT_APPL = 1;
    localparam int CAT_CUST = 2;
    localparam int CAT_DRIVE = 3;
    localparam int CAT_TUNE = 4;
    localparam logic [4:0] MASK_ALL = 5'h1F;
    localparam logic [4:0] MASK_ALL_BUT_TUNE = 5'h0F;
    // host register map
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ = 4'h5;
    localparam logic [3:0] REG_MASK = 4'h6;
    // command register bits
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;
    // irq bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_READ = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam int NV_CYCLES = 64;

    function automatic logic [4:0] cat_mask(input logic [7:0] sub,
                                            input logic discard);
        unique case (sub)
            SUB_ALL: cat_mask = discard ? MASK_ALL_BUT_TUNE : MASK_ALL;
            SUB_COMM: cat_mask = 5'h01;
            SUB_APPL: cat_mask = 5'h02;
            SUB_CUST: cat_mask = 5'h04;
            SUB_DRIVE: cat_mask = 5'h08;
            SUB_TUNE: cat_mask = 5'h10;
            default: cat_mask = 5'h00;
        endcase
    endfunction
endpackage

// ===== nv_link_if.sv
interface nv_link_if;
    logic req;
    logic we;
    logic [2:0] obj;
    logic [7:0] sub;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;
    logic busy;
    modport device(input req, we, obj, sub, wdata,
                   output ack, rdata, busy);
    modport master(output req, we, obj, sub, wdata,
                   input ack, rdata, busy);
endinterface

// ===== nv_master.sv
module nv_master (
    input wire logic clk, // clock
    input wire logic arst_n, // async reset
    nv_link_if.master link, // device link
    input wire logic [3:0] addr, // register address
    input wire logic [31:0] wdata, // write data
    input wire logic wr_stb, // write strobe
    input wire logic rd_stb, // read strobe
    input wire logic motor_still, // motor at standstill
    output logic [31:0] rdata, // read data
    output logic irq // interrupt
);
    typedef enum logic [1:0] {
        IDLE = 2'b00, WAIT = 2'b01
    } state_type;
    state_type state_reg;
    logic [2:0] obj_reg;
    logic [7:0] sub_reg;
    logic [31:0] data_reg;
    logic [31:0] rd_reg;
    logic [1:0] irq_reg;
    logic [1:0] mask_reg;
    logic we_reg;
    logic refused_reg;
    logic [1:0] ev;
    logic go;
    logic blocked;
    logic still_meta_reg;
    logic still_reg;

    assign go = wr_stb && addr == nv_pkg::REG_CMD && state_reg == IDLE;
    // save/discard only at standstill and while device idle
    assign blocked = wdata[nv_pkg::CMD_WRITE]
        && (obj_reg == nv_pkg::OBJ_SAVE || obj_reg == nv_pkg::OBJ_DISCARD)
        && (!still_reg || link.busy);

    // level from the motor side: two stages before any logic reads it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            still_meta_reg <= 1'b0;
            still_reg <= 1'b0;
        end else begin
            still_meta_reg <= motor_still;
            still_reg <= still_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= IDLE;
            link.req <= 1'b0;
            link.we <= 1'b0;
            link.obj <= 3'h0;
            link.sub <= 8'h00;
            link.wdata <= 32'h00000000;
            we_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            link.req <= 1'b0;
            unique case (state_reg)
                IDLE: if (go) begin
                    refused_reg <= blocked;
                    if (!blocked) begin
                        link.req <= 1'b1;
                        link.we <= wdata[nv_pkg::CMD_WRITE];
                        we_reg <= wdata[nv_pkg::CMD_WRITE];
                        link.obj <= obj_reg;
                        link.sub <= sub_reg;
                        link.wdata <= data_reg;
                        state_reg <= WAIT;
                    end
                end
                WAIT: if (link.ack) state_reg <= IDLE;
                default: state_reg <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            obj_reg <= 3'h0;
            sub_reg <= 8'h00;
            data_reg <= 32'h00000000;
            mask_reg <= 2'h0;
        end else if (wr_stb) begin
            if (addr == nv_pkg::REG_ADDR) begin
                obj_reg <= wdata[10:8];
                sub_reg <= wdata[7:0];
            end
            if (addr == nv_pkg::REG_DATA) data_reg <= wdata;
            if (addr == nv_pkg::REG_MASK) mask_reg <= wdata[1:0];
        end
    end

    // completion of a save is seen by polling for one
    assign ev[nv_pkg::IRQ_DONE] = state_reg == WAIT && link.ack && we_reg;
    assign ev[nv_pkg::IRQ_READ] = state_reg == WAIT && link.ack && !we_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_reg <= 32'h00000000;
            irq_reg <= nv_pkg::IRQ_RESET;
        end else begin
            if (ev[nv_pkg::IRQ_READ]) rd_reg <= link.rdata;
            // set wins over a write-one clear
            irq_reg <= (irq_reg & ~((wr_stb && addr == nv_pkg::REG_IRQ)
                ? wdata[1:0] : 2'h0)) | ev;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 32'h00000000;
            irq <= 1'b0;
        end else begin
            irq <= |(irq_reg & mask_reg);
            rdata <= 32'h00000000;
            if (rd_stb) begin
                unique case (addr)
                    nv_pkg::REG_ADDR: rdata <= {21'h0, obj_reg, sub_reg};
                    nv_pkg::REG_DATA: rdata <= data_reg;
                    nv_pkg::REG_RDATA: rdata <= rd_reg;
                    nv_pkg::REG_STATUS: rdata <= {29'h0, refused_reg,
                        link.busy, state_reg == WAIT};
                    nv_pkg::REG_IRQ: rdata <= {30'h0, irq_reg};
                    nv_pkg::REG_MASK: rdata <= {30'h0, mask_reg};
                    default: rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // nv_master

// ===== nv_link_asserts.sv
module nv_link_asserts #(
    parameter int NV_CYCLES = nv_pkg::NV_CYCLES
) (
    input wire logic clk, // clock
    input wire logic arst_n, // async reset
    input wire logic req, // request
    input wire logic we, // write
    input wire logic [2:0] obj, // object
    input wire logic [7:0] sub, // subindex
    input wire logic [31:0] wdata, // write value
    input wire logic ack, // answer
    input wire logic [31:0] rdata, // read value
    input wire logic busy // running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic key_ok;
    logic [15:0] busy_cnt;
    assign key_ok = req && we && sub >= 8'h01 && sub <= 8'h06 &&
        ((obj == nv_pkg::OBJ_SAVE && wdata == nv_pkg::SAVE_KEY) ||
         (obj == nv_pkg::OBJ_DISCARD && wdata == nv_pkg::DISCARD_KEY));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) busy_cnt <= 16'h0000;
        else busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
    end
    sequence run_seq;
        busy [*6];
    endsequence
    a_ack_after_req: assert property (req |=> ack)
        else $error("ack missing after request");
    a_ack_has_cause: assert property (ack |-> $past(req))
        else $error("ack without request");
    a_ack_one_cycle: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_req_single: assert property (req |=> !req)
        else $error("request longer than one cycle");
    a_busy_starts: assert property (key_ok && !busy |=> busy)
        else $error("key accepted without busy");
    a_busy_cause: assert property ($rose(busy) |-> $past(key_ok))
        else $error("busy without key write");
    a_busy_holds: assert property ($rose(busy) |-> run_seq)
        else $error("busy dropped early");
    a_busy_bounded: assert property (busy_cnt <= NV_CYCLES + 2)
        else $error("busy too long");
    a_no_key_busy: assert property (key_ok |-> !busy)
        else $error("save or discard sent while busy");
endmodule // nv_link_asserts

// ===== tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, arst_n = 0, wr_stb = 0, rd_stb = 0, motor_still = 1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h00000000, rdata, r, win [5], working_out [5];
    logic irq, load_pulse, restart_req, rst_seen = 0;
    int miscompares = 0, num_checks = 0, seed = 49960;
    int work [5], stored [5], mv, i, s, c;
    always #10 clk = ~clk;
    nv_link_if link();
    nv_param_store #(.NV_CYCLES(40)) nv_param_store_i(.clk(clk),
        .arst_n(arst_n), .link(link.device), .working_in(win),
        .working_out(working_out), .load_pulse(load_pulse),
        .restart_req(restart_req));
    nv_master nv_master_i(.clk(clk), .arst_n(arst_n), .link(link.master),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .motor_still(motor_still), .rdata(rdata), .irq(irq));
    nv_link_asserts #(.NV_CYCLES(40)) nv_link_asserts_i(.clk(clk),
        .arst_n(arst_n), .req(link.req), .we(link.we), .obj(link.obj),
        .sub(link.sub), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata), .busy(link.busy));
    always @(posedge clk) if (restart_req === 1'b1) rst_seen <= 1'b1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic op(input logic [2:0] o, input int sb, input logic w,
                      input logic [31:0] d);
        wr(nv_pkg::REG_ADDR, {21'h0, o, sb[7:0]});
        wr(nv_pkg::REG_DATA, d);
        wr(nv_pkg::REG_CMD, w ? 32'h00000001 : 32'h00000002);
        for (int k = 0; k < 40 && irq !== 1'b1; k++) @(posedge clk);
        rd(nv_pkg::REG_RDATA, r);
        wr(nv_pkg::REG_IRQ, 32'h00000003);
    endtask
    // wait out the store, then the subindex must report completion
    task automatic sv(input logic [2:0] o, input int sb, input logic [31:0] k);
        op(o, sb, 1'b1, k);
        // the key must still stand in the subindex while the store runs
        op(o, sb, 1'b0, 32'h00000000);
        chk(r, k);
        for (int k2 = 0; k2 < 40; k2++) begin
            rd(nv_pkg::REG_STATUS, r);
            if (r[1] === 1'b0) break;
        end
        op(o, sb, 1'b0, 32'h00000000);
        chk(r, nv_pkg::DONE_VALUE);
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, load_pulse}, 32'h00000001);
        repeat (2) @(posedge clk);
        wr(nv_pkg::REG_MASK, 32'h00000003);
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
    initial begin
        for (c = 0; c < 5; c++) win[c] = $random(seed);
        repeat (12) @(posedge clk);
        do_reset();
        for (s = 1; s <= 6; s++) begin
            op(nv_pkg::OBJ_SAVE, s, 1'b0, 32'h00000000);
            chk(r, nv_pkg::DONE_VALUE);
        end
        @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        $display("test reset values done");
        for (s = 1; s <= 6; s++) begin
            for (c = 0; c < 5; c++) begin
                work[c] = $random(seed);
                op(nv_pkg::OBJ_PARAM, c, 1'b1, work[c]);
            end
            op(nv_pkg::OBJ_MARKER, 1, 1'b0, 32'h00000000);
            chk(r, 32'h00000000);
            mv = $random(seed);
            op(nv_pkg::OBJ_MARKER, 1, 1'b1, mv);
            op(nv_pkg::OBJ_MARKER, 1, 1'b0, 32'h00000000);
            chk(r, mv);
            sv(nv_pkg::OBJ_SAVE, s, nv_pkg::SAVE_KEY);
            for (c = 0; c < 5; c++)
                if (s == 1 || c == s - 2) stored[c] = work[c];
            op(nv_pkg::OBJ_MARKER, 1, 1'b0, 32'h00000000);
            chk(r, (s == 1) ? mv : 0);
        end
        do_reset();
        for (c = 0; c < 5; c++) begin
            op(nv_pkg::OBJ_PARAM, c, 1'b0, 32'h00000000);
            chk(r, stored[c]);
            chk(working_out[c], stored[c]);
            work[c] = $random(seed);
            op(nv_pkg::OBJ_PARAM, c, 1'b1, work[c]);
        end
        // a change on the live side replaces the working value
        win[1] <= $random(seed);
        repeat (3) @(posedge clk);
        work[1] = win[1];
        $display("test save categories done");
        for (s = 1; s <= 5; s++) begin
            sv(nv_pkg::OBJ_DISCARD, s, nv_pkg::DISCARD_KEY);
            for (c = 0; c < 5; c++) begin
                op(nv_pkg::OBJ_PARAM, c, 1'b0, 32'h00000000);
                chk(r, work[c]);
            end
        end
        do_reset();
        op(nv_pkg::OBJ_PARAM, 4, 1'b0, 32'h00000000);
        chk(r, stored[4]);
        op(nv_pkg::OBJ_PARAM, 0, 1'b0, 32'h00000000);
        chk(r, 32'h00000000);
        sv(nv_pkg::OBJ_DISCARD, 6, nv_pkg::DISCARD_KEY);
        $display("test discard done");
        op(nv_pkg::OBJ_REBOOT, 1, 1'b1, nv_pkg::SAVE_KEY);
        chk({31'h0, rst_seen}, 32'h00000000);
        op(nv_pkg::OBJ_REBOOT, 1, 1'b1, nv_pkg::REBOOT_KEY);
        chk({31'h0, rst_seen}, 32'h00000001);
        $display("test reboot done");
        wr(nv_pkg::REG_MASK, 32'h00000000);
        op(nv_pkg::OBJ_MARKER, 2, 1'b1, 32'h00000005);
        rd(nv_pkg::REG_IRQ, r);
        chk(r, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        op(nv_pkg::OBJ_MARKER, 2, 1'b0, 32'h00000000);
        chk(r, 32'h00000005);
        wr(nv_pkg::REG_MASK, 32'h00000003);
        $display("test interrupt mask done");
        // motor running: the save has to be turned away
        motor_still <= 1'b0;
        op(nv_pkg::OBJ_SAVE, 2, 1'b1, nv_pkg::SAVE_KEY);
        rd(nv_pkg::REG_STATUS, r);
        chk({31'h0, r[2]}, 32'h00000001);
        motor_still <= 1'b1;
        // second save sent while the first still runs
        wr(nv_pkg::REG_ADDR, {21'h0, nv_pkg::OBJ_SAVE, 8'h03});
        wr(nv_pkg::REG_CMD, 32'h00000001);
        wr(nv_pkg::REG_ADDR, {21'h0, nv_pkg::OBJ_SAVE, 8'h04});
        wr(nv_pkg::REG_CMD, 32'h00000001);
        rd(nv_pkg::REG_STATUS, r);
        chk({31'h0, r[2]}, 32'h00000001);
        repeat (50) @(posedge clk);
        $display("test refusals done");
        wrap_up();
    end
endmodule // tb_top
